// ==== logic/wcd_counter.sv ====
// watchdog count, period expiry and window check
`timescale 1ns/1ps
`default_nettype none
module wcd_counter (
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    ce_i,
  input  wire logic                    tick_i,
  input  wire logic                    enable_i,
  input  wire logic                    run_i,
  input  wire logic                    clear_i,
  input  wire logic [4:0]              period_i,
  input  wire logic [2:0]              window_i,
  output logic                         window_open_o,
  output logic                         expire_o
);
  logic [wcd_pkg::CNT_W-1:0] count_reg;
  logic [wcd_pkg::CNT_W-1:0] count_next;
  logic [4:0]                eff_period;
  logic [wcd_pkg::CNT_W-1:0] terminal;
  logic [wcd_pkg::CNT_W-1:0] threshold;
  logic [3:0]                open_eighths;

  // ==========================================================
  // decode period and window
  assign eff_period   = (period_i > wcd_pkg::PER_MAX) ? wcd_pkg::PER_FALLBACK : period_i;
  assign terminal     = (wcd_pkg::CNT_W'(1) << (eff_period + 5'(wcd_pkg::PER_BASE_EXP))) - wcd_pkg::CNT_W'(1);
  assign open_eighths = (window_i >= wcd_pkg::WIN_FULL_MIN) ? wcd_pkg::EIGHTHS_ALL
                                                            : 4'({1'b0, window_i} + 4'h1);
  // closed part is (8 - open) eighths of the period
  assign threshold    = wcd_pkg::CNT_W'(wcd_pkg::EIGHTHS_ALL - open_eighths) << (eff_period + 5'h2);
  assign window_open_o = (count_reg >= threshold);
  assign expire_o      = enable_i & run_i & tick_i & (count_reg == terminal);

  // next count: disable or clear restarts, sleep suspension holds
  assign count_next = (!enable_i || clear_i || expire_o) ? '0 :
                      (run_i && tick_i) ? count_reg + wcd_pkg::CNT_W'(1) : count_reg;

  // count register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      count_reg <= '0;
    else if (ce_i)
      count_reg <= count_next;
  end
endmodule
`default_nettype wire

// ==== logic/wcd_pkg.sv ====
// constants for the watchdog configuration decoder
// Function
// - clock select 000, 001, 010 pick low, tap or secondary oscillator tick.
// - clock select 111 gives clock choice to software; 011-110 are reserved.
// - window select 111/110 fully open; 101..000 open 75 down to 12.5 percent.
// - window select 111 lets software change window freely; fixed codes need keyed access.
// - mode 11 runs always, mode 10 suspends in sleep; software enable ignored.
// - mode 01 follows software enable; mode 00 keeps watchdog off.
// - period codes 0..18 divide by 2^5..2^23; codes 19..30 act as 1:32.
// - period 11111 loads 01011 and stays software writable; others copied and locked.
package wcd_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] CFG_IDX         = 16'h8009;
  localparam logic [15:0] CTRL_IDX        = 16'h8010;
  localparam logic [15:0] STAT_IDX        = 16'h8011;
  localparam logic [15:0] CLEAR_IDX       = 16'h8012;
  localparam logic [15:0] KEY_IDX         = 16'h8013;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
  localparam logic [7:0]  UNLOCK_KEY      = 8'h5A;

  // ==========================================================
  // configuration word fields
  localparam int CFG_CLK_LSB  = 11;
  localparam int CFG_WIN_LSB  = 8;
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_PER_LSB  = 0;
  localparam logic [15:0] CFG_FIXED_ONES = 16'hC080; // unimplemented bits read as one

  // ==========================================================
  // runtime control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_PER_LSB = 1;
  localparam int CTRL_WIN_LSB = 8;
  localparam int CTRL_CLK_LSB = 12;

  // status fields
  localparam int STAT_OPEN_BIT    = 0;
  localparam int STAT_RUN_BIT     = 1;
  localparam int STAT_TMO_BIT     = 2;
  localparam int STAT_VIOL_BIT    = 3;
  localparam int STAT_UNLOCK_BIT  = 4;

  // ==========================================================
  // codes
  localparam logic [2:0] CLK_LFOSC    = 3'h0;
  localparam logic [2:0] CLK_MFTAP    = 3'h1;
  localparam logic [2:0] CLK_SECONDARY_CRYSTAL_OSC     = 3'h2;
  localparam logic [2:0] CLK_SOFT     = 3'h7;
  localparam logic [2:0] WIN_SOFT     = 3'h7;
  localparam logic [2:0] WIN_FULL_MIN = 3'h6;
  localparam logic [1:0] MODE_ALWAYS  = 2'h3;
  localparam logic [1:0] MODE_AWAKE   = 2'h2;
  localparam logic [1:0] MODE_SOFT    = 2'h1;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [4:0] PER_SOFT     = 5'h1F;
  localparam logic [4:0] PER_SOFT_DEF = 5'h0B;
  localparam logic [4:0] PER_MAX      = 5'h12;
  localparam logic [4:0] PER_FALLBACK = 5'h00;
  localparam int         PER_BASE_EXP = 5;
  localparam int         CNT_W        = 24;
  localparam logic [3:0] EIGHTHS_ALL  = 4'h8;

  typedef enum logic [1:0] {
    WCD_IDLE  = 2'b00,
    WCD_SETUP = 2'b01,
    WCD_DONE  = 2'b11
  } wcd_apb_t;
endpackage

// ==== logic/wcd_top.sv ====
// watchdog configuration decoder with runtime control over apb
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module wcd_top (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] nv_config_i,
  input  wire logic [2:0]  ref_tick_i,
  input  wire logic        sleep_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             wdt_reset_o,
  output logic             wdt_running_o
);
  // ==========================================================
  // configuration fields
  logic [2:0] cfg_clk;
  logic [2:0] cfg_win;
  logic [1:0] cfg_mode;
  logic [4:0] cfg_per;
  logic       per_soft;
  logic       win_soft;
  logic       clk_soft;
  logic [15:0] cfg_view;

  assign cfg_clk  = nv_config_i[wcd_pkg::CFG_CLK_LSB +: 3];
  assign cfg_win  = nv_config_i[wcd_pkg::CFG_WIN_LSB +: 3];
  assign cfg_mode = nv_config_i[wcd_pkg::CFG_MODE_LSB +: 2];
  assign cfg_per  = nv_config_i[wcd_pkg::CFG_PER_LSB +: 5];
  assign per_soft = (cfg_per == wcd_pkg::PER_SOFT);
  assign win_soft = (cfg_win == wcd_pkg::WIN_SOFT);
  assign clk_soft = (cfg_clk == wcd_pkg::CLK_SOFT);
  assign cfg_view = nv_config_i | wcd_pkg::CFG_FIXED_ONES;

  // ==========================================================
  // runtime state
  logic       en_reg;
  logic [4:0] per_reg;
  logic [2:0] win_reg;
  logic [2:0] clk_reg;
  logic       unlock_reg;
  logic       tmo_reg;
  logic       viol_reg;
  logic       rst_reg;
  logic       running_reg;
  logic       ready_reg;
  logic       err_reg;
  logic [31:0] rdata_reg;
  wcd_pkg::wcd_apb_t apb_reg;

  // ==========================================================
  // apb decode
  logic        addr_ok;
  logic [15:0] idx;
  logic        hit_cfg;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_clear;
  logic        hit_key;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        wr_ctrl;
  logic        wr_clear;
  logic        wr_key;
  logic        wr_stat;
  logic        bad;
  logic [31:0] rd_mux;

  assign idx       = paddr_i[17:2];
  assign addr_ok   = (paddr_i[31:18] == 14'h0000) && (paddr_i[1:0] == 2'h0);
  assign hit_cfg   = addr_ok && (idx == wcd_pkg::CFG_IDX);
  assign hit_ctrl  = addr_ok && (idx == wcd_pkg::CTRL_IDX);
  assign hit_stat  = addr_ok && (idx == wcd_pkg::STAT_IDX);
  assign hit_clear = addr_ok && (idx == wcd_pkg::CLEAR_IDX);
  assign hit_key   = addr_ok && (idx == wcd_pkg::KEY_IDX);
  assign mapped    = hit_cfg | hit_ctrl | hit_stat | hit_clear | hit_key;
  assign setup     = psel_i & ~penable_i;
  assign access    = psel_i & penable_i & ready_reg;
  assign wr_ctrl   = access & pwrite_i & hit_ctrl;
  assign wr_clear  = access & pwrite_i & hit_clear;
  assign wr_key    = access & pwrite_i & hit_key;
  assign wr_stat   = access & pwrite_i & hit_stat;
  // unmapped addresses and writes to the fixed configuration word are errors
  assign bad       = ~mapped | (pwrite_i & hit_cfg);

  // ==========================================================
  // counter status and read mux
  logic       win_open;
  logic       expire;
  logic [31:0] stat_view;
  logic [31:0] ctrl_view;

  assign ctrl_view = {16'h0000, 1'b0, clk_reg, 1'b0, win_reg, 2'h0, per_reg, en_reg};
  assign stat_view = {27'h000_0000, unlock_reg, viol_reg, tmo_reg, running_reg, win_open};
  assign rd_mux    = hit_cfg  ? {16'h0000, cfg_view} :
                     hit_ctrl ? ctrl_view :
                     hit_stat ? stat_view : wcd_pkg::UNMAPPED_DATA;

  // ==========================================================
  // run decision and clock choice
  logic       enable;
  logic       run;
  logic [2:0] clk_eff;
  logic       tick;
  logic       clk_valid;

  // mode 11 always, 10 awake only, 01 software bit, 00 off
  assign enable = (cfg_mode == wcd_pkg::MODE_ALWAYS) | (cfg_mode == wcd_pkg::MODE_AWAKE) |
                  ((cfg_mode == wcd_pkg::MODE_SOFT) & en_reg);
  assign run    = enable & ~((cfg_mode == wcd_pkg::MODE_AWAKE) & sleep_i);
  assign clk_eff   = clk_soft ? clk_reg : cfg_clk;
  // reserved codes select no clock, so the count stands still
  assign clk_valid = (clk_eff == wcd_pkg::CLK_LFOSC) | (clk_eff == wcd_pkg::CLK_MFTAP) |
                     (clk_eff == wcd_pkg::CLK_SECONDARY_CRYSTAL_OSC);
  assign tick      = clk_valid & ref_tick_i[clk_eff[1:0]];

  // ==========================================================
  // runtime control next values
  logic       ctrl_win_ok;
  logic [4:0] per_next;
  logic [2:0] win_next;
  logic [2:0] clk_next;
  logic       en_next;
  logic       unlock_next;
  logic       clear_req;
  logic       viol_evt;

  assign ctrl_win_ok = win_soft | unlock_reg;
  assign en_next   = wr_ctrl ? pwdata_i[wcd_pkg::CTRL_EN_BIT] : en_reg;
  assign per_next  = (wr_ctrl && per_soft) ? pwdata_i[wcd_pkg::CTRL_PER_LSB +: 5] : per_reg;
  assign win_next  = (wr_ctrl && ctrl_win_ok) ? pwdata_i[wcd_pkg::CTRL_WIN_LSB +: 3] : win_reg;
  assign clk_next  = (wr_ctrl && clk_soft) ? pwdata_i[wcd_pkg::CTRL_CLK_LSB +: 3] : clk_reg;
  // a key arms one window write; any control write uses it up
  assign unlock_next = wr_key ? (pwdata_i[7:0] == wcd_pkg::UNLOCK_KEY) :
                       wr_ctrl ? 1'b0 : unlock_reg;
  assign clear_req = wr_clear & enable;
  assign viol_evt  = clear_req & ~win_open;

  wcd_counter u_counter (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .ce_i          (ce_i),
    .tick_i        (tick),
    .enable_i      (enable),
    .run_i         (run),
    .clear_i       (clear_req),
    .period_i      (per_reg),
    .window_i      (win_reg),
    .window_open_o (win_open),
    .expire_o      (expire)
  );

  // ==========================================================
  // runtime control registers; reset loads period and window from configuration, zeroes the rest
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      en_reg     <= 1'b0;
      per_reg    <= per_soft ? wcd_pkg::PER_SOFT_DEF : cfg_per;
      win_reg    <= cfg_win;
      clk_reg    <= wcd_pkg::CLK_LFOSC;
      unlock_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      en_reg     <= en_next;
      per_reg    <= per_next;
      win_reg    <= win_next;
      clk_reg    <= clk_next;
      unlock_reg <= unlock_next;
    end
  end

  // ==========================================================
  // sticky causes: a new event wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tmo_reg  <= 1'b0;
      viol_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      tmo_reg  <= expire | (tmo_reg & ~(wr_stat & pwdata_i[wcd_pkg::STAT_TMO_BIT]));
      viol_reg <= viol_evt | (viol_reg & ~(wr_stat & pwdata_i[wcd_pkg::STAT_VIOL_BIT]));
    end
  end

  // reset request pulse and running flag
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rst_reg     <= 1'b0;
      running_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      rst_reg     <= expire | viol_evt;
      running_reg <= run;
    end
  end

  // ==========================================================
  // apb slave: ready in the first access cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      apb_reg   <= wcd_pkg::WCD_IDLE;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      case (apb_reg)
        wcd_pkg::WCD_IDLE:
        begin
          if (setup)
          begin
            apb_reg   <= wcd_pkg::WCD_SETUP;
            ready_reg <= 1'b1;
            err_reg   <= bad;
            rdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
          end
        end
        wcd_pkg::WCD_SETUP:
        begin
          if (access)
          begin
            apb_reg   <= wcd_pkg::WCD_DONE;
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
          end
        end
        wcd_pkg::WCD_DONE:
        begin
          apb_reg   <= wcd_pkg::WCD_IDLE;
          ready_reg <= 1'b0;
          if (setup)
          begin
            apb_reg   <= wcd_pkg::WCD_SETUP;
            ready_reg <= 1'b1;
            err_reg   <= bad;
            rdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
          end
        end
        default:
        begin
          apb_reg   <= wcd_pkg::WCD_IDLE;
          ready_reg <= 1'b0;
          err_reg   <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign prdata_o      = rdata_reg;
  assign pready_o      = ready_reg;
  assign pslverr_o     = err_reg;
  assign wdt_reset_o   = rst_reg;
  assign wdt_running_o = running_reg;
endmodule
`default_nettype wire

// ==== tb/watchdog_config_decode_bench.sv ====
// self-checking bench for the watchdog configuration decoder
`timescale 1ns/1ps
`default_nettype none
module watchdog_config_decode_bench;
  // ==========================================================
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] cfg = 16'hFFFF;
  logic [2:0]  tick = 3'h0;
  logic        slp = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] pa = 32'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        wrst;
  logic        wrun;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          checked = 0;
  int          pulses = 0;
  int          seed = 32'h47F0;
  // clock and tally of reset pulses
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (wrst === 1'b1)
      pulses++;
  end
  wcd_top u_dut (
    .clk_i(clk), .rstn_i(rstn), .ce_i(ce), .nv_config_i(cfg), .ref_tick_i(tick), .sleep_i(slp),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .wdt_reset_o(wrst), .wdt_running_o(wrun)
  );
  // ==========================================================
  // expectation helpers
  function automatic logic [15:0] mk(input logic [2:0] c, input logic [2:0] w, input logic [1:0] md,
                                     input logic [4:0] p);
    return {2'b11, c, w, 1'b1, md, p};
  endfunction
  function automatic int span(input logic [4:0] p);
    return (p > wcd_pkg::PER_MAX) ? 32 : (32 << p);
  endfunction
  function automatic logic [31:0] ctl(input logic [15:0] c);
    logic [4:0] p;
    p = (c[4:0] == wcd_pkg::PER_SOFT) ? wcd_pkg::PER_SOFT_DEF : c[4:0];
    return {21'h0, c[10:8], 2'b00, p, 1'b0};
  endfunction
  // ==========================================================
  // compare, bus cycle, reset, tick and clear tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= {14'h0, idx, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (prdy !== 1'b1)
      n_errors++;
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic boot(input logic [15:0] c);
    @(posedge clk);
    rstn <= 1'b0;
    cfg <= c;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, wcd_pkg::CFG_IDX, 0, rd, err);
    cmp("config", {16'h0, c | wcd_pkg::CFG_FIXED_ONES}, rd);
    bus(1'b0, wcd_pkg::CTRL_IDX, 0, rd, err);
    cmp("ctrl reset", ctl(c), rd);
  endtask
  // ticks on the chosen source, random noise on the others
  task automatic run(input int b, input int n, output int dn);
    int p0;
    logic [2:0] m;
    p0 = pulses;
    m = 3'h1 << b;
    repeat (n)
    begin
      @(posedge clk);
      tick <= m | (3'($random(seed)) & ~m);
      @(posedge clk);
      tick <= 3'($random(seed)) & ~m;
    end
    @(posedge clk);
    tick <= 3'h0;
    repeat (3) @(posedge clk);
    dn = pulses - p0;
  endtask
  task automatic clr(output int dn);
    int p0;
    p0 = pulses;
    bus(1'b1, wcd_pkg::CLEAR_IDX, 32'h1, rd, err);
    repeat (3) @(posedge clk);
    dn = pulses - p0;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    logic [4:0] pers [5] = '{5'h00, 5'h01, 5'h13, 5'h1E, 5'h02};
    logic [31:0] d;
    int dn;
    for (int i = 0; i < 5; i++)
    begin
      boot(mk(3'(i % 3), 3'h7, wcd_pkg::MODE_ALWAYS, pers[i]));
      run(i % 3, span(pers[i]) - 1, dn);
      cmp("early", 0, dn);
      run(i % 3, 1, dn);
      cmp("expiry", 1, dn);
      cmp("running", 1, wrun);
      bus(1'b0, wcd_pkg::STAT_IDX, 0, rd, err);
      cmp("timeout flag", 1, rd[wcd_pkg::STAT_TMO_BIT]);
    end
    boot(mk(3'h0, 3'h7, wcd_pkg::MODE_OFF, 5'h00));
    run(0, 40, dn);
    cmp("off mode", 0, dn);
    boot(mk(3'h0, 3'h7, wcd_pkg::MODE_SOFT, 5'h00));
    run(0, 40, dn);
    cmp("sw off", 0, dn);
    bus(1'b1, wcd_pkg::CTRL_IDX, 32'h0000_0701, rd, err);
    run(0, 32, dn);
    cmp("sw on", 1, dn);
    boot(mk(3'h0, 3'h7, wcd_pkg::MODE_AWAKE, 5'h00));
    slp <= 1'b1;
    run(0, 40, dn);
    cmp("asleep", 0, dn);
    slp <= 1'b0;
    run(0, 32, dn);
    cmp("awake", 1, dn);
    boot(mk(3'h4, 3'h7, wcd_pkg::MODE_ALWAYS, 5'h00));
    for (int b = 0; b < 3; b++)
    begin
      run(b, 40, dn);
      cmp("reserved clock", 0, dn);
    end
    // a low clock enable freezes the count, which then resumes from zero
    boot(mk(3'h0, 3'h7, wcd_pkg::MODE_ALWAYS, 5'h00));
    ce <= 1'b0;
    run(0, 40, dn);
    cmp("frozen", 0, dn);
    ce <= 1'b1;
    run(0, 32, dn);
    cmp("thawed", 1, dn);
    // software-owned settings, then locked ones, with only the window opened by the key
    boot(mk(3'h7, 3'h7, wcd_pkg::MODE_SOFT, 5'h1F));
    d = 32'($random(seed)) & 32'h0000_773F;
    bus(1'b1, wcd_pkg::CTRL_IDX, d, rd, err);
    bus(1'b0, wcd_pkg::CTRL_IDX, 0, rd, err);
    cmp("open ctrl", d, rd);
    bus(1'b1, wcd_pkg::CTRL_IDX, 32'h0000_2701, rd, err);
    run(2, 32, dn);
    cmp("sw clock", 1, dn);
    boot(mk(3'h1, 3'h3, wcd_pkg::MODE_SOFT, 5'h05));
    d = 32'($random(seed));
    bus(1'b1, wcd_pkg::CTRL_IDX, d, rd, err);
    bus(1'b0, wcd_pkg::CTRL_IDX, 0, rd, err);
    cmp("locked ctrl", ctl(cfg) | {31'h0, d[0]}, rd);
    bus(1'b1, wcd_pkg::KEY_IDX, {24'h0, wcd_pkg::UNLOCK_KEY}, rd, err);
    bus(1'b1, wcd_pkg::CTRL_IDX, 32'h0000_0600, rd, err);
    bus(1'b1, wcd_pkg::CTRL_IDX, 32'h0000_0100, rd, err);
    bus(1'b0, wcd_pkg::CTRL_IDX, 0, rd, err);
    cmp("keyed window", 32'h0000_060A, rd);
    bus(1'b0, 16'h0000, 0, rd, err);
    cmp("unmapped", 1, err);
    bus(1'b1, wcd_pkg::CFG_IDX, 0, rd, err);
    cmp("config write", 1, err);
    // clear one tick before and at the opening of window sizes 000..101, at zero for 110 and 111
    for (int w = 0; w < 8; w++)
    begin
      for (int o = (w > 5); o < 2; o++)
      begin
        boot(mk(3'h0, 3'(w), wcd_pkg::MODE_ALWAYS, 5'h00));
        run(0, ((w > 5) ? 0 : (7 - w) * 4) - 1 + o, dn);
        clr(dn);
        cmp("window clear", 1 - o, dn);
        bus(1'b0, wcd_pkg::STAT_IDX, 0, rd, err);
        cmp("violation flag", 1 - o, rd[wcd_pkg::STAT_VIOL_BIT]);
      end
    end
    bus(1'b0, wcd_pkg::STAT_IDX, 0, rd, err);
    cmp("no violation", 0, rd[3]);
    stop_test();
  end
  // watchdog: the whole sequence needs well under 20 us
  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// ==== tb/wcd_monitor.sv ====
// assertion checker for the watchdog configuration decoder ports
`timescale 1ns/1ps
`default_nettype none
module wcd_monitor (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ce_i,
  input wire logic [15:0] nv_config_i,
  input wire logic [2:0]  ref_tick_i,
  input wire logic        sleep_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        wdt_reset_o,
  input wire logic        wdt_running_o
);
  // ==========================================================
  // bus phases and mode decode
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic [1:0] mode = nv_config_i[6:5];
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_done;
    psel_i && penable_i && pready_o;
  endsequence
  // ==========================================================
  // bus answer timing and refusals
  chk_ready_on_time: assert property (s_setup |=> pready_o) else $error("ready late");
  chk_ready_single: assert property (s_done |=> !pready_o) else $error("ready held");
  chk_unmapped_refused: assert property (s_setup ##0 paddr_i == 32'h0 |=> pslverr_o) else $error("no error");
  chk_config_readback: assert property (s_setup ##0 (!pwrite_i && paddr_i == 32'h0002_0024)
    |=> prdata_o == {16'h0, nv_config_i | wcd_pkg::CFG_FIXED_ONES}) else $error("config read wrong");
  // ==========================================================
  // watchdog mode and reset pulse
  chk_pulse_single: assert property (wdt_reset_o |=> !wdt_reset_o) else $error("reset pulse long");
  chk_off_silent: assert property (mode == wcd_pkg::MODE_OFF |-> !wdt_running_o && !wdt_reset_o)
    else $error("active while off");
  chk_always_runs: assert property ((mode == wcd_pkg::MODE_ALWAYS && nv_config_i[13:11] <= 3'h2)[*4]
    |-> wdt_running_o) else $error("idle in always mode");
  chk_sleep_holds: assert property ((mode == wcd_pkg::MODE_AWAKE && sleep_i)[*2] |-> !wdt_reset_o)
    else $error("expiry in sleep");
endmodule
bind wcd_top wcd_monitor u_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .nv_config_i(nv_config_i), .ref_tick_i(ref_tick_i),
  .sleep_i(sleep_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .wdt_reset_o(wdt_reset_o), .wdt_running_o(wdt_running_o)
);
`default_nettype wire
